// ### verilog/uec_ctrl.sv
// Endpoint control and status registers of a low-speed USB function.
// Assumes a CPU register strobe port and a decoded packet engine on the line side.
// Summary of operation
// - Shared TX PID bit picks DATA1/DATA0
// - Buffer select routes data EP1 or EP2
// - EP2 IN NAKed when select points EP1
// - NAK EP1/2 IN when disabled or done
// - Force resume drives K state
// - Force resume never sets resume flag
// - Four-bit transmit byte count field
// - Status-out bit auto answers status OUT
// - Bits 3,2 enable EP2, EP1
// - Bits 1,0 force stall EP2, EP1
// - Expected EP0 receive PID bit
// - SETUP token sets setup-detect bit
// - IN token sets in-detect bit
// - OUT token sets out-detect bit
// - Last EP0 DATA byte count readable
// - EP0 received bytes at 0xef
// - EP0 transmit bytes at 0xe7
// - Done flag set after host ACK
// - Resume flag set on suspended activity
module uec_ctrl (
    input  wire logic       i_clk,           // 10 MHz clock
    input  wire logic       i_srst,          // Sync reset, high
    input  wire logic [7:0] i_reg_addr,      // Register address
    input  wire logic       i_reg_wr,        // Write strobe
    input  wire logic       i_reg_rd,        // Read strobe
    input  wire logic [7:0] i_reg_wdata,     // Write data
    output logic      [7:0] o_reg_rdata,     // Read data, registered
    input  wire logic       i_tok_valid,     // Token decoded pulse
    input  wire logic [3:0] i_tok_pid,       // Token PID
    input  wire logic [3:0] i_tok_ep,        // Token endpoint
    input  wire logic       i_rx_byte_valid, // EP0 received byte pulse
    input  wire logic [7:0] i_rx_byte,       // EP0 received byte
    input  wire logic       i_rx_end,        // End of EP0 DATA packet
    input  wire logic       i_rx_pid_data1,  // Received packet was DATA1
    input  wire logic       i_host_ack,      // Host ACK pulse
    input  wire logic       i_line_ready,    // Line takes next byte
    input  wire logic       i_suspend_flag,  // Suspend bit of USB unit
    input  wire logic       i_bus_activity,  // Pin-level activity, async
    input  wire logic       i_done_clear,    // Software clears done flag
    input  wire logic       i_resume_clear,  // Software clears resume flag
    output logic [1:0]      o_answer,        // Answer kind, valid one cycle
    output logic            o_answer_valid,  // Answer strobe
    output logic            o_tx_pid_data1,  // DATA1 on this packet
    output logic            o_tx_ep2,        // Packet for EP2
    output logic            o_tx_valid,      // Byte valid to line
    output logic      [7:0] o_tx_byte,       // Byte to line
    output logic            o_tx_last,       // Last byte of packet
    output logic            o_status_ack,    // Auto ACK of status OUT
    output logic            o_rx_pid_match,  // Received PID as expected
    output logic            o_drive_k,       // Drive K on data lines
    output logic            o_ep12_tx_done_flag, // Done flag
    output logic            o_bus_resume_flag    // Resume flag
);
    logic [7:0] txc_reg, txc_next;           // Shared transmit control
    logic [7:0] epc_reg, epc_next;           // Endpoint control
    logic [7:0] sta_reg, sta_next;           // EP0 status
    logic [7:0] rxd_reg, rxd_next;           // EP0 receive data
    logic [7:0] txd0_reg, txd0_next;         // EP0 transmit data
    logic [7:0] rdata_reg, rdata_next;       // Read data
    logic       done_reg, done_next;         // Done flag
    logic       res_reg, res_next;           // Resume flag
    logic [3:0] cnt_reg, cnt_next;           // Bytes left to send
    logic [3:0] rxc_reg, rxc_next;           // Bytes in current packet
    logic [1:0] ans_reg, ans_next;           // Answer kind
    logic       ansv_reg, ansv_next;         // Answer strobe
    logic       sack_reg, sack_next;         // Status ack
    logic       pm_reg, pm_next;             // PID match
    logic       act_s1_reg, act_s2_reg;      // Activity synchroniser
    uec_pkg::uec_state_t st_reg, st_next;    // Sequencer state
    logic       fifo_ready, fifo_valid;      // FIFO handshakes
    logic [7:0] fifo_data;                   // FIFO head
    logic       fifo_pop, fifo_flush, fifo_push; // FIFO controls
    logic       in_ep12, in_ep2, tok_in, tok_out; // Token decode

    // Register address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // Shared transmit buffer
    uec_fifo #(
        .WIDTH(uec_pkg::DATA_W),
        .DEPTH(uec_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_flush (fifo_flush),
        .i_valid (fifo_push),
        .o_ready (fifo_ready),
        .i_data  (i_reg_wdata),
        .o_valid (fifo_valid),
        .i_ready (fifo_pop),
        .o_data  (fifo_data),
        .o_count ()
    );

    // CPU writes to buffer; full buffer drops the byte
    assign fifo_push  = i_reg_wr && hit(i_reg_addr, uec_pkg::ADDR_EP12_TX_BUFFER) && fifo_ready;
    assign fifo_pop   = (st_reg == uec_pkg::UEC_SEND) && i_line_ready && fifo_valid;
    assign fifo_flush = (st_reg == uec_pkg::UEC_WACK) && i_host_ack;

    // Token decode
    always_comb begin
        tok_in  = i_tok_valid && (i_tok_pid == uec_pkg::PID_IN);
        tok_out = i_tok_valid && (i_tok_pid == uec_pkg::PID_OUT);
        in_ep12 = tok_in && (i_tok_ep == 4'h1 || i_tok_ep == 4'h2);
        in_ep2  = i_tok_ep == 4'h2;
    end

    // Register file next values
    always_comb begin
        txc_next  = txc_reg;
        epc_next  = epc_reg;
        sta_next  = sta_reg;
        rxd_next  = rxd_reg;
        txd0_next = txd0_reg;
        rdata_next = rdata_reg;
        rxc_next  = rxc_reg;
        pm_next   = pm_reg;
        if (i_reg_wr) begin
            if (hit(i_reg_addr, uec_pkg::ADDR_EP12_TX_CONTROL)) begin
                txc_next = i_reg_wdata;
            end
            if (hit(i_reg_addr, uec_pkg::ADDR_ENDPOINT_CTRL)) begin
                epc_next = i_reg_wdata & uec_pkg::EPC_MASK;
            end
            if (hit(i_reg_addr, uec_pkg::ADDR_EP0_STATUS)) begin
                sta_next[uec_pkg::STA_EP0_RX_EXPECTED_PID_BIT] = i_reg_wdata[uec_pkg::STA_EP0_RX_EXPECTED_PID_BIT];
            end
            if (hit(i_reg_addr, uec_pkg::ADDR_EP0_TX_DATA)) begin
                txd0_next = i_reg_wdata;
            end
        end
        // Token detect bits reflect the last token
        if (i_tok_valid) begin
            sta_next[uec_pkg::STA_SETUP_BIT] = i_tok_pid == uec_pkg::PID_SETUP;
            sta_next[uec_pkg::STA_IN_BIT] = tok_in;
            sta_next[uec_pkg::STA_OUT_BIT] = tok_out;
        end
        // EP0 receive bytes and count
        if (i_rx_byte_valid) begin
            rxd_next = i_rx_byte;
            rxc_next = rxc_reg + 4'h1;
        end
        if (i_rx_end) begin
            sta_next[uec_pkg::CNT_MSB:0] = rxc_reg;
            rxc_next = '0;
            pm_next = i_rx_pid_data1 == sta_reg[uec_pkg::STA_EP0_RX_EXPECTED_PID_BIT];
        end
        // Read mux
        if (i_reg_rd) begin
            case (i_reg_addr)
                uec_pkg::ADDR_EP0_TX_DATA:     rdata_next = txd0_reg;
                uec_pkg::ADDR_EP12_TX_CONTROL: rdata_next = txc_reg;
                uec_pkg::ADDR_ENDPOINT_CTRL:   rdata_next = epc_reg;
                uec_pkg::ADDR_EP0_STATUS:      rdata_next = sta_reg;
                uec_pkg::ADDR_EP0_RX_DATA:     rdata_next = rxd_reg;
                default:                       rdata_next = uec_pkg::REG_RESET;
            endcase
        end
    end

    // Sequencer and flags
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        ans_next  = uec_pkg::UEC_ANS_NONE;
        ansv_next = 1'b0;
        sack_next = 1'b0;
        done_next = done_reg;
        res_next  = res_reg;
        if (i_done_clear) done_next = 1'b0;
        if (i_resume_clear) res_next = 1'b0;
        // Only synchronised line activity sets the flag, never force resume
        if (i_suspend_flag && act_s2_reg) res_next = 1'b1;
        // Auto status OUT answer
        if (tok_out && i_tok_ep == 4'h0 && epc_reg[uec_pkg::EPC_AUTO_STATUS_OUT_BIT]) begin
            sack_next = 1'b1;
        end
        case (st_reg)
            uec_pkg::UEC_IDLE: begin
                if (in_ep12) begin
                    ansv_next = 1'b1;
                    if (in_ep2 ? epc_reg[uec_pkg::EPC_ST2_BIT] : epc_reg[uec_pkg::EPC_ST1_BIT]) begin
                        ans_next = uec_pkg::UEC_ANS_STALL;
                    end else if (!txc_reg[uec_pkg::TXC_EN_BIT] || done_reg) begin
                        ans_next = uec_pkg::UEC_ANS_NAK;
                    end else if (in_ep2 ? !epc_reg[uec_pkg::EPC_EP2_ENABLE_BIT] : !epc_reg[uec_pkg::EPC_EP1_ENABLE_BIT]) begin
                        ans_next = uec_pkg::UEC_ANS_NAK;
                    end else if (in_ep2 != txc_reg[uec_pkg::TXC_SEL_BIT]) begin
                        ans_next = uec_pkg::UEC_ANS_NAK;
                    end else begin
                        ans_next = uec_pkg::UEC_ANS_DATA;
                        cnt_next = txc_reg[uec_pkg::CNT_MSB:0];
                        st_next  = (txc_reg[uec_pkg::CNT_MSB:0] == 4'h0) ? uec_pkg::UEC_WACK : uec_pkg::UEC_SEND;
                    end
                end
            end
            uec_pkg::UEC_SEND: begin
                if (fifo_pop) begin
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1) st_next = uec_pkg::UEC_WACK;
                end
            end
            uec_pkg::UEC_WACK: begin
                if (i_host_ack) begin
                    done_next = 1'b1;
                    st_next   = uec_pkg::UEC_IDLE;
                end else if (i_tok_valid) begin
                    st_next   = uec_pkg::UEC_IDLE; // Lost ACK, retry later
                end
            end
            default: st_next = uec_pkg::UEC_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            txc_reg    <= uec_pkg::REG_RESET;
            epc_reg    <= uec_pkg::REG_RESET;
            sta_reg    <= uec_pkg::REG_RESET;
            rxd_reg    <= uec_pkg::REG_RESET;
            txd0_reg   <= uec_pkg::REG_RESET;
            rdata_reg  <= uec_pkg::REG_RESET;
            done_reg   <= 1'b0;
            res_reg    <= 1'b0;
            cnt_reg    <= '0;
            rxc_reg    <= '0;
            ans_reg    <= uec_pkg::UEC_ANS_NONE;
            ansv_reg   <= 1'b0;
            sack_reg   <= 1'b0;
            pm_reg     <= 1'b0;
            act_s1_reg <= 1'b0;
            act_s2_reg <= 1'b0;
            st_reg     <= uec_pkg::UEC_IDLE;
        end else begin
            txc_reg    <= txc_next;
            epc_reg    <= epc_next;
            sta_reg    <= sta_next;
            rxd_reg    <= rxd_next;
            txd0_reg   <= txd0_next;
            rdata_reg  <= rdata_next;
            done_reg   <= done_next;
            res_reg    <= res_next;
            cnt_reg    <= cnt_next;
            rxc_reg    <= rxc_next;
            ans_reg    <= ans_next;
            ansv_reg   <= ansv_next;
            sack_reg   <= sack_next;
            pm_reg     <= pm_next;
            act_s1_reg <= i_bus_activity;
            act_s2_reg <= act_s1_reg;
            st_reg     <= st_next;
        end
    end

    // Outputs
    assign o_reg_rdata         = rdata_reg;
    assign o_answer            = ans_reg;
    assign o_answer_valid      = ansv_reg;
    assign o_tx_pid_data1      = txc_reg[uec_pkg::TXC_PID_BIT];
    assign o_tx_ep2            = txc_reg[uec_pkg::TXC_SEL_BIT];
    assign o_tx_valid          = (st_reg == uec_pkg::UEC_SEND) && fifo_valid;
    assign o_tx_byte           = fifo_data;
    assign o_tx_last           = cnt_reg == 4'h1;
    assign o_status_ack        = sack_reg;
    assign o_rx_pid_match      = pm_reg;
    assign o_drive_k           = txc_reg[uec_pkg::TXC_RESUME_BIT];
    assign o_ep12_tx_done_flag = done_reg;
    assign o_bus_resume_flag   = res_reg;

    // Assertions
    nak_disabled_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_reg == uec_pkg::UEC_IDLE && in_ep12 && !txc_reg[uec_pkg::TXC_EN_BIT]
         && !epc_reg[uec_pkg::EPC_ST1_BIT] && !epc_reg[uec_pkg::EPC_ST2_BIT])
        |=> ansv_reg && ans_reg == uec_pkg::UEC_ANS_NAK)
        else $error("IN with transmit disabled not NAKed");
    sel_nak_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_reg == uec_pkg::UEC_IDLE && in_ep12 && in_ep2 && !done_reg && txc_reg[uec_pkg::TXC_EN_BIT]
         && !epc_reg[uec_pkg::EPC_ST2_BIT] && epc_reg[uec_pkg::EPC_EP2_ENABLE_BIT] && !txc_reg[uec_pkg::TXC_SEL_BIT])
        |=> ans_reg == uec_pkg::UEC_ANS_NAK)
        else $error("EP2 IN with EP1 selected not NAKed");
    resume_k_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_reg_wr && hit(i_reg_addr, uec_pkg::ADDR_EP12_TX_CONTROL))
        |=> o_drive_k == $past(i_reg_wdata[uec_pkg::TXC_RESUME_BIT]))
        else $error("K not driven while resume forced");
    no_self_resume_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (!res_reg && !act_s2_reg) |=> !res_reg)
        else $error("Resume flag set without bus activity");
    setup_detect_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_tok_valid && i_tok_pid == uec_pkg::PID_SETUP) |=> sta_reg[uec_pkg::STA_SETUP_BIT])
        else $error("Setup detect not set");
    in_detect_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tok_in |=> sta_reg[uec_pkg::STA_IN_BIT] && !sta_reg[uec_pkg::STA_OUT_BIT])
        else $error("In detect wrong");
    out_detect_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tok_out |=> sta_reg[uec_pkg::STA_OUT_BIT] && !sta_reg[uec_pkg::STA_IN_BIT])
        else $error("Out detect wrong");
    done_set_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (st_reg == uec_pkg::UEC_WACK && i_host_ack) |=> done_reg ##1 (done_reg || $past(i_done_clear)))
        else $error("Done flag not set after ack");
    status_out_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (tok_out && i_tok_ep == 4'h0 && epc_reg[uec_pkg::EPC_AUTO_STATUS_OUT_BIT]) |=> o_status_ack)
        else $error("Status OUT not answered");
endmodule

// ### verilog/uec_pkg.sv
// Package for the endpoint control and status block.
// Assumes an 8-bit special-function register bus inside the controller.
package uec_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_EP12_TX_BUFFER  = 8'he6; // Shared EP1/2 transmit data
    localparam logic [7:0] ADDR_EP0_TX_DATA     = 8'he7; // EP0 transmit data
    localparam logic [7:0] ADDR_EP12_TX_CONTROL = 8'heb; // EP1/2 transmit control
    localparam logic [7:0] ADDR_ENDPOINT_CTRL   = 8'hec; // Endpoint control
    localparam logic [7:0] ADDR_EP0_STATUS      = 8'hed; // EP0 status
    localparam logic [7:0] ADDR_EP0_RX_DATA     = 8'hef; // EP0 receive data
    localparam logic [7:0] REG_RESET            = 8'h00; // Reset value of all registers
    // Transmit control fields
    localparam int TXC_PID_BIT    = 7; // Data PID
    localparam int TXC_SEL_BIT    = 6; // Buffer select
    localparam int TXC_EN_BIT     = 5; // Transmit enable
    localparam int TXC_RESUME_BIT = 4; // Force resume
    // Endpoint control fields
    localparam int EPC_AUTO_STATUS_OUT_BIT   = 4; // Auto status out
    localparam int EPC_EP2_ENABLE_BIT   = 3; // EP2 enable
    localparam int EPC_EP1_ENABLE_BIT   = 2; // EP1 enable
    localparam int EPC_ST2_BIT    = 1; // EP2 stall
    localparam int EPC_ST1_BIT    = 0; // EP1 stall
    localparam logic [7:0] EPC_MASK = 8'h1f; // Writable endpoint control bits
    // EP0 status fields
    localparam int STA_EP0_RX_EXPECTED_PID_BIT   = 7; // Expected receive PID
    localparam int STA_SETUP_BIT  = 6; // Setup token seen
    localparam int STA_IN_BIT     = 5; // In token seen
    localparam int STA_OUT_BIT    = 4; // Out token seen
    localparam int CNT_MSB        = 3; // Top bit of byte counts
    // Token PIDs (4-bit)
    localparam logic [3:0] PID_SETUP = 4'hd; // Setup token b1101
    localparam logic [3:0] PID_IN    = 4'h9; // In token
    localparam logic [3:0] PID_OUT   = 4'h1; // Out token
    // Handshake answers
    typedef enum logic [1:0] {
        UEC_ANS_NONE  = 2'b00, // No answer
        UEC_ANS_DATA  = 2'b01, // Data packet follows
        UEC_ANS_NAK   = 2'b10, // Negative answer
        UEC_ANS_STALL = 2'b11  // Stall answer
    } uec_ans_t;
    // Transmit sequencer states
    typedef enum logic [1:0] {
        UEC_IDLE = 2'b00, // Waiting for IN
        UEC_SEND = 2'b01, // Streaming bytes
        UEC_WACK = 2'b10  // Waiting for host ACK
    } uec_state_t;
    localparam int FIFO_DEPTH = 8; // Transmit buffer depth
    localparam int DATA_W     = 8; // Byte width
endpackage

// ### verilog/uec_fifo.sv
// Parameterised byte FIFO for the shared transmit path.
// Assumes one clock, synchronous active-high reset.
module uec_fifo #(
    parameter int WIDTH = 8, // Word width
    parameter int DEPTH = 8  // Word count, power of two
) (
    input  wire logic             i_clk,     // Clock
    input  wire logic             i_srst,    // Sync reset
    input  wire logic             i_flush,   // Drop contents
    input  wire logic             i_valid,   // Write valid
    output logic                  o_ready,   // Not full
    input  wire logic [WIDTH-1:0] i_data,    // Write data
    output logic                  o_valid,   // Not empty
    input  wire logic             i_ready,   // Read accept
    output logic      [WIDTH-1:0] o_data,    // Head word
    output logic [$clog2(DEPTH):0] o_count   // Words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];       // Storage
    logic [AW:0]      wr_reg, wr_next;       // Write pointer
    logic [AW:0]      rd_reg, rd_next;       // Read pointer
    logic             push, pop;             // Accepted moves

    // Handshakes and pointer updates
    always_comb begin
        o_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        o_valid = wr_reg != rd_reg;
        push    = i_valid && o_ready;
        pop     = i_ready && o_valid;
        wr_next = wr_reg + (AW+1)'(push);
        rd_next = rd_reg + (AW+1)'(pop);
        if (i_flush) begin
            wr_next = '0;
            rd_next = '0;
        end
    end

    // Registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= i_data;
        end
    end

    assign o_data  = mem_reg[rd_reg[AW-1:0]];
    assign o_count = wr_reg - rd_reg;
endmodule

// ### test/uec_host_model.sv
// Host controller model driving decoded tokens, handshakes and line pacing.
// Assumes it shares the bench clock and drives just after each rising edge.
module uec_host_model (
    input  wire logic       i_clk,        // Bench clock
    input  wire logic       i_slow,       // Stall the line at random
    output logic            o_tok_valid,  // Token strobe
    output logic      [3:0] o_tok_pid,    // Token PID
    output logic      [3:0] o_tok_ep,     // Token endpoint
    output logic            o_host_ack,   // ACK of device data
    output logic            o_line_ready  // Line takes a byte
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_tok_valid = 1'b0;
        o_tok_pid = 4'h0;
        o_tok_ep = 4'h0;
        o_host_ack = 1'b0;
        o_line_ready = 1'b1;
    end
    // Line pacing, prompt or stalling
    always @(posedge i_clk) begin
        o_line_ready <= #1 i_slow ? 1'($urandom_range(1, 0)) : 1'b1;
    end
    // One token; fields inverted after it
    task automatic token(input logic [3:0] pid, input logic [3:0] ep);
        @(posedge i_clk);
        #1;
        o_tok_valid = 1'b1;
        o_tok_pid = pid;
        o_tok_ep = ep;
        @(posedge i_clk);
        #1;
        o_tok_valid = 1'b0;
        o_tok_pid = ~pid;
        o_tok_ep = ~ep;
    endtask
    // One handshake pulse
    task automatic ack();
        @(posedge i_clk);
        #1;
        o_host_ack = 1'b1;
        @(posedge i_clk);
        #1;
        o_host_ack = 1'b0;
    endtask
endmodule

// ### test/usb_endpoint_ctrl_status_tb_top.sv
// Self-checking bench for the endpoint control block.
// Assumes the host model drives the token side and this bench the CPU side.
module usb_endpoint_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_clk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0; // Clock, reset, strobes
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_rx_byte = 8'h00;    // Bus and receive data
    logic       i_rx_byte_valid = 1'b0, i_rx_end = 1'b0, i_rx_pid_data1 = 1'b0; // Receive side
    logic       i_suspend_flag = 1'b0, i_bus_activity = 1'b0, slow = 1'b0;    // Suspend, activity, pacing
    logic       i_done_clear = 1'b0, i_resume_clear = 1'b0;                   // Software clears
    wire        tok_valid, host_ack, line_ready, o_answer_valid, o_tx_valid, o_tx_last; // Handshakes
    wire  [3:0] tok_pid, tok_ep;                                              // Token fields
    wire  [1:0] o_answer;                                                     // Answer kind
    wire  [7:0] o_reg_rdata, o_tx_byte;                                       // Data out
    wire        o_tx_pid_data1, o_tx_ep2, o_status_ack, o_rx_pid_match, o_drive_k; // Status
    wire        o_ep12_tx_done_flag, o_bus_resume_flag;                       // Flags
    int         failures = 0, cmp_count = 0, c, e, ep, x, w;                  // Counters and scratch
    logic [7:0] r, expq[$], gotq[$], adr[7] = '{8'he6, 8'he7, 8'heb, 8'hec, 8'hed, 8'hef, 8'he0}; // Model
    logic [3:0] pids[3] = '{uec_pkg::PID_SETUP, uec_pkg::PID_IN, uec_pkg::PID_OUT}; // Token kinds
    always #50 i_clk = ~i_clk;
    uec_host_model host (.i_clk(i_clk), .i_slow(slow), .o_tok_valid(tok_valid), .o_tok_pid(tok_pid),
        .o_tok_ep(tok_ep), .o_host_ack(host_ack), .o_line_ready(line_ready));
    uec_ctrl uut (.i_tok_valid(tok_valid), .i_tok_pid(tok_pid), .i_tok_ep(tok_ep), .i_host_ack(host_ack),
        .i_line_ready(line_ready), .*);
    // Expected answer to an IN: stall first, then enables, then routing
    function automatic int exp_ans(int ctl, int epc, int n);
        if (epc[n-1]) return 3;
        if (!ctl[5] || !epc[n+1] || ctl[6] != (n == 2)) return 2;
        return 1;
    endfunction
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        cmp_count++;
        if (got !== ex) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask
    // Register write, one cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {i_reg_addr, i_reg_wdata} = {a, d};
        pulse(i_reg_wr);
    endtask
    // Register read, data registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_reg_addr = a;
        pulse(i_reg_rd);
        d = o_reg_rdata;
    endtask
    // Single-cycle pulse on a bench input
    task automatic pulse(ref logic s);
        @(posedge i_clk);
        #1;
        s = 1'b1;
        @(posedge i_clk);
        #1;
        s = 1'b0;
    endtask
    // Counts and verdict
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Bytes accepted by the line
    always @(negedge i_clk) begin
        if (o_tx_valid && line_ready) begin
            chk("last flag", {7'h0, gotq.size() == 7}, {7'h0, o_tx_last});
            gotq.push_back(o_tx_byte);
        end
    end
    initial begin
        x = int'($urandom(32'h2cdb));
        repeat (8) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        foreach (adr[i]) begin
            rd(adr[i], r);
            chk("reset value", uec_pkg::REG_RESET, r);
        end
        r = 8'($urandom);
        wr(uec_pkg::ADDR_EP12_TX_CONTROL, r);
        chk("drive k", {7'h0, r[4]}, {7'h0, o_drive_k});
        chk("tx pid sel", {6'h0, r[7:6]}, {6'h0, o_tx_pid_data1, o_tx_ep2});
        rd(uec_pkg::ADDR_EP12_TX_CONTROL, x[7:0]);
        chk("tx control", r, x[7:0]);
        wr(uec_pkg::ADDR_ENDPOINT_CTRL, 8'hff);
        rd(uec_pkg::ADDR_ENDPOINT_CTRL, r);
        chk("endpoint control", 8'h1f, r);
        wr(uec_pkg::ADDR_EP0_TX_DATA, 8'h5a);
        rd(uec_pkg::ADDR_EP0_TX_DATA, r);
        chk("ep0 tx data", 8'h5a, r);
        wr(uec_pkg::ADDR_EP0_STATUS, 8'hff);
        rd(uec_pkg::ADDR_EP0_STATUS, r);
        chk("ep0 status", 8'h80, r);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            c = int'($urandom_range(7, 0)) << 5;
            e = int'($urandom_range(15, 0));
            ep = 1 + int'($urandom_range(1, 0));
            if (exp_ans(c, e, ep) == 1) continue;
            wr(uec_pkg::ADDR_ENDPOINT_CTRL, 8'(e));
            wr(uec_pkg::ADDR_EP12_TX_CONTROL, 8'(c));
            host.token(uec_pkg::PID_IN, 4'(ep));
            chk("refusal", 8'(exp_ans(c, e, ep) + 4), {5'h0, o_answer_valid, o_answer});
        end
        $display("test refusals done");
        slow = 1'b1;
        for (int n = 1; n <= 2; n++) begin
            expq = {};
            gotq = {};
            for (int k = 0; k < 9; k++) begin
                r = 8'($urandom);
                wr(uec_pkg::ADDR_EP12_TX_BUFFER, r);
                if (k < 8) expq.push_back(r);
            end
            wr(uec_pkg::ADDR_ENDPOINT_CTRL, n == 1 ? 8'h04 : 8'h08);
            wr(uec_pkg::ADDR_EP12_TX_CONTROL, n == 1 ? 8'ha8 : 8'h68);
            host.token(uec_pkg::PID_IN, 4'(n));
            chk("data answer", 8'h05, {5'h0, o_answer_valid, o_answer});
            chk("pid and ep", {6'h0, n == 1, n == 2}, {6'h0, o_tx_pid_data1, o_tx_ep2});
            for (w = 0; w < 200 && gotq.size() < 8; w++) @(posedge i_clk);
            if (w == 200) begin
                failures++;
                break;
            end
            host.ack();
            @(posedge i_clk);
            #1;
            foreach (expq[i]) chk("tx byte", expq[i], gotq[i]);
            chk("byte count", 8'h08, 8'(gotq.size()));
            chk("done flag", 8'h01, {7'h0, o_ep12_tx_done_flag});
            host.token(uec_pkg::PID_IN, 4'(n));
            chk("done refusal", 8'h06, {5'h0, o_answer_valid, o_answer});
            pulse(i_done_clear);
            chk("done cleared", 8'h00, {7'h0, o_ep12_tx_done_flag});
        end
        slow = 1'b0;
        $display("test transfers done");
        wr(uec_pkg::ADDR_ENDPOINT_CTRL, 8'h10);
        foreach (pids[i]) begin
            host.token(pids[i], 4'h0);
            chk("status ack", {7'h0, pids[i] == uec_pkg::PID_OUT}, {7'h0, o_status_ack});
            rd(uec_pkg::ADDR_EP0_STATUS, r);
            chk("token bits", 8'h40 >> i, r & 8'h70);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            #1;
            i_rx_byte_valid = 1'b1;
            for (int j = 0; j < 3 + 2 * k; j++) begin
                i_rx_byte = 8'($urandom);
                @(posedge i_clk);
                #1;
            end
            {i_rx_byte_valid, i_rx_end, i_rx_pid_data1} = {1'b0, 1'b1, k == 0};
            @(posedge i_clk);
            #1;
            i_rx_end = 1'b0;
            chk("pid match", {7'h0, k == 0}, {7'h0, o_rx_pid_match});
            rd(uec_pkg::ADDR_EP0_STATUS, r);
            chk("rx count", 8'(3 + 2 * k), r & 8'h0f);
            rd(uec_pkg::ADDR_EP0_RX_DATA, r);
            chk("rx data", i_rx_byte, r);
        end
        $display("test endpoint zero done");
        i_suspend_flag = 1'b1;
        wr(uec_pkg::ADDR_EP12_TX_CONTROL, 8'h10);
        repeat (4) @(posedge i_clk);
        #1;
        chk("forced resume flag", 8'h00, {7'h0, o_bus_resume_flag});
        wr(uec_pkg::ADDR_EP12_TX_CONTROL, 8'h00);
        i_bus_activity = 1'b1;
        for (w = 0; w < 8 && o_bus_resume_flag !== 1'b1; w++) @(posedge i_clk);
        #1;
        chk("resume flag", 8'h01, {7'h0, o_bus_resume_flag});
        {i_bus_activity, i_suspend_flag} = 2'b00;
        pulse(i_resume_clear);
        chk("resume cleared", 8'h00, {7'h0, o_bus_resume_flag});
        $display("test resume done");
        results();
    end
endmodule
